// File: acti_core.sv
// Command interpreter for label text and trace data transfer
`timescale 1ns/1ns

module acti_core
    import acti_pkg::*;
#(
    parameter int HOLD_CYC = KEY_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command bytes from the bus interface
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // Answer bytes to the bus interface
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Clear sources
    input wire logic dev_clear,
    input wire logic status_clear,
    input wire logic panel_clear_key,
    // Raster side
    input wire logic [8:0] disp_x,
    input wire logic [5:0] disp_col,
    input wire logic label_hits_trace,
    output acti_disp_s disp,
    output logic [3:0] label_row,
    output logic syntax_err
);
    acti_state_e st_r;
    acti_kind_e kind_r;
    logic [7:0] first_r;
    logic sel_r;
    logic line_r;
    logic [8:0] idx_r;
    logic [2:0] sub_r;
    logic [9:0] acc_r;
    logic neg_r;
    logic dig_r;
    logic [7:0] hi_r;
    logic signed [10:0] best_r;
    logic [8:0] bestx_r;
    logic [7:0] tx_data_r;
    logic tx_valid_r;
    logic rx_ready_r;
    logic [3:0] row_r;
    logic serr_r;
    logic wr_en_r;
    logic wr_sel_r;
    logic [8:0] wr_addr_r;
    logic signed [10:0] wr_val_r;
    logic signed [10:0] mem_q_r;
    logic [5:0] lcol_r;
    acti_disp_s disp_r;
    logic [7:0] lbl_r [2][LABEL_LEN];
    logic signed [10:0] mem [2][TRACE_PTS];
    logic [23:0] fmt_chars;
    logic hold_clr;
    logic [7:0] ch;
    logic [7:0] fmt_byte;
    logic [2:0] sub_last;
    logic [8:0] n_last;

    assign rx_ready = rx_ready_r;
    assign tx_data = tx_data_r;
    assign tx_valid = tx_valid_r;
    assign disp = disp_r;
    assign label_row = row_r;
    assign syntax_err = serr_r;

    function automatic logic code_known(input logic [15:0] c);
        logic k;
        k = 1'b0;
        for (int i = 0; i < $size(KNOWN_CODES); i++) begin
            if (c == KNOWN_CODES[i]) begin
                k = 1'b1;
            end
        end
        return k;
    endfunction

    // Saturate to the display range, park low values at the blank level
    function automatic logic signed [10:0] clamp(
        input logic signed [15:0] v);
        if (v < 16'(DISP_MIN)) begin
            return TRACE_BLANK;
        end else if (v > 16'(TRACE_MAX)) begin
            return TRACE_MAX;
        end else begin
            return v[10:0];
        end
    endfunction

    // Byte classification
    wire take = rx_valid && rx_ready_r;
    wire [7:0] b = rx_data;
    wire is_letter = b >= CH_A && b <= CH_Z;
    wire is_digit = b >= CH_ZERO && b <= CH_NINE;
    wire is_ctrl = b <= CH_CTRL_TOP;
    wire [3:0] dval = 4'(b - CH_ZERO);
    wire [15:0] code = {first_r, b};
    wire in_cmd2 = take && st_r == ST_CMD2;

    // Number and address shaping
    wire signed [15:0] acc16 = $signed({6'h00, acc_r});
    wire signed [15:0] ain16 = neg_r ? -acc16 : acc16;
    wire signed [15:0] bin16 = $signed({hi_r, b});
    wire [15:0] mem16 = {{5{mem_q_r[10]}}, mem_q_r};
    wire [8:0] rd_addr = idx_r > TRACE_LAST ? TRACE_LAST : idx_r;
    wire [8:0] dx = disp_x > TRACE_LAST ? TRACE_LAST : disp_x;
    wire [2:0] fk = sub_r < 3'h3 ? sub_r : 3'(sub_r - 3'h4);
    wire peak_y = sub_r > 3'h3;
    wire signed [10:0] fmt_in = kind_r != TK_PEAK ? mem_q_r
        : (peak_y ? best_r : $signed({2'h0, bestx_r}));
    wire [8:0] lo_idx = 9'(idx_r - 9'(LABEL_LEN + 1));
    wire lbl_cmd = code == CODE_UPPER_WRITE || code == CODE_LOWER_WRITE
        || code == CODE_UPPER_RESTORE || code == CODE_LOWER_RESTORE;
    wire lbl_start = in_cmd2 && lbl_cmd;
    wire lbl_line = b == CH_L;
    wire lbl_put = take && st_r == ST_LABEL && !is_ctrl
        && lcol_r < 6'(LABEL_LEN);
    wire err_set = in_cmd2 && !(is_letter && code_known(code));
    wire clr_any = dev_clear || status_clear || hold_clr;
    wire lbl_off = row_r == 4'h0 || label_hits_trace
        || disp_col >= 6'(LABEL_LEN);

    acti_fmt3 u_fmt (
        .val(fmt_in),
        .chars(fmt_chars)
    );

    acti_hold #(
        .HOLD_CYC(HOLD_CYC)
    ) u_hold (
        .clk(clk),
        .rstn(rstn),
        .key(panel_clear_key),
        .fire(hold_clr)
    );

    // Per-kind field length and transfer length
    always_comb begin
        case (kind_r)
            TK_ASCII: sub_last = idx_r == TRACE_LAST ? 3'h2 : 3'h3;
            TK_BIN: sub_last = 3'h1;
            TK_LABEL: sub_last = 3'h0;
            default: sub_last = 3'h6;
        endcase
        case (kind_r)
            TK_LABEL: n_last = DUMP_LAST;
            TK_PEAK: n_last = 9'h000;
            default: n_last = TRACE_LAST;
        endcase
    end

    // Next answer character
    always_comb begin
        case (fk)
            3'h0: fmt_byte = fmt_chars[23:16];
            3'h1: fmt_byte = fmt_chars[15:8];
            default: fmt_byte = fmt_chars[7:0];
        endcase
        case (kind_r)
            TK_ASCII: ch = sub_r == 3'h3 ? CH_COMMA : fmt_byte;
            TK_BIN: ch = sub_r == 3'h0 ? mem16[15:8] : mem16[7:0];
            TK_LABEL: begin
                if (idx_r < 9'(LABEL_LEN)) begin
                    ch = lbl_r[0][idx_r[5:0]];
                end else if (idx_r == 9'(LABEL_LEN)
                        || idx_r == DUMP_LAST) begin
                    ch = CH_ETX;
                end else begin
                    ch = lbl_r[1][lo_idx[5:0]];
                end
            end
            default: ch = sub_r == 3'h3 ? CH_COMMA : fmt_byte;
        endcase
    end

    // Parser and answer sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            kind_r <= TK_ASCII;
            first_r <= 8'h00;
            sel_r <= 1'b0;
            line_r <= 1'b0;
            idx_r <= 9'h000;
            sub_r <= 3'h0;
            acc_r <= 10'h000;
            neg_r <= 1'b0;
            dig_r <= 1'b0;
            hi_r <= 8'h00;
            best_r <= 11'h000;
            bestx_r <= 9'h000;
            tx_data_r <= 8'h00;
            tx_valid_r <= 1'b0;
            rx_ready_r <= 1'b1;
            row_r <= ROW_POWERON;
            wr_en_r <= 1'b0;
            wr_sel_r <= 1'b0;
            wr_addr_r <= 9'h000;
            wr_val_r <= 11'h000;
        end else begin
            wr_en_r <= 1'b0;
            wr_sel_r <= sel_r;
            wr_addr_r <= idx_r;
            case (st_r)
                ST_IDLE: begin
                    // Non-letters between codes are skipped
                    if (take && is_letter) begin
                        first_r <= b;
                        st_r <= ST_CMD2;
                    end
                end
                ST_CMD2: begin
                    if (take) begin
                        st_r <= ST_IDLE;
                        idx_r <= 9'h000;
                        sub_r <= 3'h0;
                        acc_r <= 10'h000;
                        neg_r <= 1'b0;
                        dig_r <= 1'b0;
                        sel_r <= b == CH_B;
                        case (code)
                            CODE_UPPER_WRITE, CODE_LOWER_WRITE: begin
                                line_r <= lbl_line;
                                st_r <= ST_LABEL;
                            end
                            CODE_ROW_SELECT: st_r <= ST_LPNUM;
                            CODE_T1_AOUT, CODE_T2_AOUT: begin
                                kind_r <= TK_ASCII;
                                rx_ready_r <= 1'b0;
                                st_r <= ST_TXLD;
                            end
                            CODE_T1_BOUT, CODE_T2_BOUT: begin
                                kind_r <= TK_BIN;
                                rx_ready_r <= 1'b0;
                                st_r <= ST_TXLD;
                            end
                            CODE_LABEL_DUMP: begin
                                kind_r <= TK_LABEL;
                                rx_ready_r <= 1'b0;
                                st_r <= ST_TXLD;
                            end
                            CODE_T1_AIN, CODE_T2_AIN: st_r <= ST_AIN;
                            CODE_T1_BIN, CODE_T2_BIN: st_r <= ST_BINH;
                            CODE_T1_PEAK, CODE_T2_PEAK: begin
                                sel_r <= first_r == CH_B;
                                rx_ready_r <= 1'b0;
                                st_r <= ST_PEAK;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_LABEL: begin
                    if (take && is_ctrl) begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_LPNUM: begin
                    // Each digit replaces the row; out-of-range values leave the row alone
                    if (take && is_digit) begin
                        if (dval <= ROW_MAX) begin
                            row_r <= dval;
                        end
                    end else if (take && is_letter) begin
                        first_r <= b;
                        st_r <= ST_CMD2;
                    end else if (take) begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_AIN: begin
                    if (take && is_digit) begin
                        if (acc_r < 10'h064) begin
                            acc_r <= 10'(acc_r * 10'h00A + 10'(dval));
                        end
                        dig_r <= 1'b1;
                    end else if (take && b == CH_MINUS) begin
                        neg_r <= 1'b1;
                    end else if (take) begin
                        // Any other byte closes the pending value
                        if (dig_r) begin
                            wr_en_r <= 1'b1;
                            wr_val_r <= clamp(ain16);
                            idx_r <= idx_r + 9'h001;
                        end
                        acc_r <= 10'h000;
                        neg_r <= 1'b0;
                        dig_r <= 1'b0;
                        if (is_letter) begin
                            first_r <= b;
                            st_r <= ST_CMD2;
                        end else if (b == CH_SEMI
                                || (dig_r && idx_r == TRACE_LAST)) begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_BINH: begin
                    if (take) begin
                        hi_r <= b;
                        st_r <= ST_BINL;
                    end
                end
                ST_BINL: begin
                    if (take) begin
                        wr_en_r <= 1'b1;
                        wr_val_r <= clamp(bin16);
                        idx_r <= idx_r + 9'h001;
                        st_r <= idx_r == TRACE_LAST ? ST_IDLE : ST_BINH;
                    end
                end
                ST_PEAK: begin
                    // Read data lags the address by one cycle
                    idx_r <= idx_r + 9'h001;
                    if (idx_r != 9'h000
                            && (idx_r == 9'h001 || mem_q_r > best_r)) begin
                        best_r <= mem_q_r;
                        bestx_r <= 9'(idx_r - 9'h001);
                    end
                    if (idx_r == 9'(TRACE_PTS)) begin
                        kind_r <= TK_PEAK;
                        idx_r <= 9'h000;
                        st_r <= ST_TXLD;
                    end
                end
                ST_TXLD: st_r <= ST_TXGO;
                ST_TXGO: begin
                    if (!tx_valid_r) begin
                        tx_data_r <= ch;
                        tx_valid_r <= 1'b1;
                    end else if (tx_ready) begin
                        tx_valid_r <= 1'b0;
                        if (sub_r != sub_last) begin
                            sub_r <= sub_r + 3'h1;
                        end else begin
                            sub_r <= 3'h0;
                            if (idx_r == n_last) begin
                                rx_ready_r <= 1'b1;
                                st_r <= ST_IDLE;
                            end else begin
                                idx_r <= idx_r + 9'h001;
                                st_r <= ST_TXLD;
                            end
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Trace memory: no reset, one write port, three read ports (this one plus the two raster reads)
    always_ff @(posedge clk) begin
        if (wr_en_r) begin
            mem[wr_sel_r][wr_addr_r] <= wr_val_r;
        end
        mem_q_r <= mem[sel_r][rd_addr];
    end

    // Label lines; write and restore both start from blank text
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lcol_r <= 6'h00;
            for (int l = 0; l < 2; l++) begin
                for (int i = 0; i < LABEL_LEN; i++) begin
                    lbl_r[l][i] <= CH_SPACE;
                end
            end
        end else if (lbl_start) begin
            lcol_r <= 6'h00;
            for (int i = 0; i < LABEL_LEN; i++) begin
                lbl_r[lbl_line][i] <= CH_SPACE;
            end
        end else if (lbl_put) begin
            lbl_r[line_r][lcol_r] <= b;
            lcol_r <= lcol_r + 6'h01;
        end
    end

    // Syntax error flag; a new error beats a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serr_r <= 1'b0;
        end else begin
            serr_r <= err_set || (serr_r && !clr_any);
        end
    end

    // Raster read-out, one cycle behind the column inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_r <= '0;
        end else begin
            disp_r.level1 <= mem[0][dx];
            disp_r.blank1 <= mem[0][dx] < DISP_MIN;
            disp_r.level2 <= mem[1][dx];
            disp_r.blank2 <= mem[1][dx] < DISP_MIN;
            disp_r.upper_ch <= lbl_off ? CH_SPACE
                : lbl_r[0][disp_col];
            disp_r.lower_ch <= lbl_off ? CH_SPACE
                : lbl_r[1][disp_col];
        end
    end
endmodule

// File: acti_pkg.sv
// Shared constants, codes and types of the annotation and trace interpreter
package acti_pkg;

    // Clock and key hold timing
    localparam int CLK_HZ = 50_000_000;
    localparam int KEY_HOLD_MS = 2000;
    localparam int KEY_HOLD_CYC = KEY_HOLD_MS * (CLK_HZ / 1000);

    // Trace and label geometry
    localparam int TRACE_PTS = 481;
    localparam logic [8:0] TRACE_LAST = 9'(TRACE_PTS - 1);
    localparam int LABEL_LEN = 60;
    localparam int DUMP_LEN = 2 * LABEL_LEN + 2;
    localparam logic [8:0] DUMP_LAST = 9'(DUMP_LEN - 1);
    localparam logic [3:0] ROW_POWERON = 4'h8;
    localparam logic [3:0] ROW_MAX = 4'h8;

    // Trace levels, 11-bit two's complement (-50, -48, 975)
    localparam logic signed [10:0] TRACE_BLANK = 11'h7CE;
    localparam logic signed [10:0] DISP_MIN = 11'h7D0;
    localparam logic signed [10:0] TRACE_MAX = 11'h3CF;

    // Character codes
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_CTRL_TOP = 8'h1F;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_L = 8'h4C;
    localparam logic [7:0] CH_Z = 8'h5A;

    // Command codes handled here
    localparam logic [15:0] CODE_UPPER_WRITE = 16'h4C55;
    localparam logic [15:0] CODE_LOWER_WRITE = 16'h4C4C;
    localparam logic [15:0] CODE_UPPER_RESTORE = 16'h5255;
    localparam logic [15:0] CODE_LOWER_RESTORE = 16'h524C;
    localparam logic [15:0] CODE_ROW_SELECT = 16'h4C50;
    localparam logic [15:0] CODE_LABEL_DUMP = 16'h4353;
    localparam logic [15:0] CODE_T1_AOUT = 16'h5441;
    localparam logic [15:0] CODE_T2_AOUT = 16'h5442;
    localparam logic [15:0] CODE_T1_BOUT = 16'h4241;
    localparam logic [15:0] CODE_T2_BOUT = 16'h4242;
    localparam logic [15:0] CODE_T1_AIN = 16'h4941;
    localparam logic [15:0] CODE_T2_AIN = 16'h4942;
    localparam logic [15:0] CODE_T1_BIN = 16'h4A41;
    localparam logic [15:0] CODE_T2_BIN = 16'h4A42;
    localparam logic [15:0] CODE_T1_PEAK = 16'h4150;
    localparam logic [15:0] CODE_T2_PEAK = 16'h4250;

    // Every legal code; the last twelve belong to other blocks
    localparam logic [15:0] KNOWN_CODES [28] = '{
        CODE_UPPER_WRITE, CODE_LOWER_WRITE, CODE_UPPER_RESTORE,
        CODE_LOWER_RESTORE, CODE_ROW_SELECT, CODE_LABEL_DUMP,
        CODE_T1_AOUT, CODE_T2_AOUT, CODE_T1_BOUT, CODE_T2_BOUT,
        CODE_T1_AIN, CODE_T2_AIN, CODE_T1_BIN, CODE_T2_BIN,
        CODE_T1_PEAK, CODE_T2_PEAK,
        16'h5859, 16'h4F49, 16'h4650, 16'h4341, 16'h4342, 16'h5453,
        16'h5253, 16'h4F46, 16'h4143, 16'h4243, 16'h4443, 16'h4943};

    // Parser states
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_CMD2 = 10'h002,
        ST_LABEL = 10'h004,
        ST_LPNUM = 10'h008,
        ST_AIN = 10'h010,
        ST_BINH = 10'h020,
        ST_BINL = 10'h040,
        ST_PEAK = 10'h080,
        ST_TXLD = 10'h100,
        ST_TXGO = 10'h200
    } acti_state_e;

    // Kind of answer being sent
    typedef enum logic [1:0] {
        TK_ASCII = 2'h0,
        TK_BIN = 2'h1,
        TK_LABEL = 2'h2,
        TK_PEAK = 2'h3
    } acti_kind_e;

    // What the raster logic sees for one column
    typedef struct packed {
        logic signed [10:0] level1;
        logic blank1;
        logic signed [10:0] level2;
        logic blank2;
        logic [7:0] upper_ch;
        logic [7:0] lower_ch;
    } acti_disp_s;

endpackage

// File: acti_fmt3.sv
// Three-character decimal field for one trace coordinate
`timescale 1ns/1ns
module acti_fmt3
    import acti_pkg::*;
(
    // Value in, characters out, first character in the top byte
    input wire logic signed [10:0] val,
    output logic [23:0] chars
);
    wire neg = val[10];
    wire [10:0] mag = neg ? 11'(~val + 11'h001) : val;
    // Negative fields only have room for two digits
    wire [9:0] mc = (neg && mag > 11'h063) ? 10'h063 : mag[9:0];
    wire [9:0] hun = mc / 10'h064;
    wire [9:0] ten = (mc / 10'h00A) % 10'h00A;
    wire [9:0] one = mc % 10'h00A;

    // Leading zeros kept, minus takes the hundreds place
    assign chars[23:16] = neg ? CH_MINUS : CH_ZERO + hun[7:0];
    assign chars[15:8] = CH_ZERO + ten[7:0];
    assign chars[7:0] = CH_ZERO + one[7:0];
endmodule

// File: acti_hold.sv
// Front-panel clear key: synchroniser and long-press detector
`timescale 1ns/1ns
module acti_hold
    import acti_pkg::*;
#(
    parameter int HOLD_CYC = KEY_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Key pin, high while pressed
    input wire logic key,
    // One-cycle pulse once the key has been held long enough
    output logic fire
);
    logic s1_r;
    logic s2_r;
    logic [31:0] cnt_r;
    logic fire_r;

    assign fire = fire_r;

    // Two flops before anything looks at the pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= key;
            s2_r <= s1_r;
        end
    end

    // Count held cycles; fire once, then wait for release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 32'h0;
            fire_r <= 1'b0;
        end else begin
            fire_r <= s2_r && cnt_r == 32'(HOLD_CYC - 1);
            if (!s2_r) begin
                cnt_r <= 32'h0;
            end else if (cnt_r != 32'(HOLD_CYC)) begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
endmodule

// File: acti_core_asserts.sv
// Port checker for the label and trace interpreter
`timescale 1ns/1ns
module acti_core_asserts
    import acti_pkg::*;
(
    // Clock, reset and byte handshakes
    input wire logic clk,
    input wire logic rstn,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    // Clears and display
    input wire logic dev_clear,
    input wire logic status_clear,
    input wire logic label_hits_trace,
    input wire acti_disp_s disp,
    input wire logic [3:0] label_row,
    input wire logic syntax_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // A byte taken at a clear edge may raise the error again
    wire take_w = rx_valid && rx_ready;
    wire sp_w = disp.upper_ch == CH_SPACE && disp.lower_ch == CH_SPACE;
    property p_err; $rose(syntax_err) |-> $past(take_w); endproperty
    a_err: assert property (p_err) else $error("error with no byte");
    property p_dclr; dev_clear && !take_w |=> !syntax_err; endproperty
    a_dclr: assert property (p_dclr) else $error("clear ignored");
    property p_sclr; status_clear && !take_w |=> !syntax_err; endproperty
    a_sclr: assert property (p_sclr) else $error("poll ignored");
    property p_row; label_row <= ROW_MAX; endproperty
    a_row: assert property (p_row) else $error("row range");
    property p_row0; label_row == 4'h0 |=> sp_w; endproperty
    a_row0: assert property (p_row0) else $error("row 0 shown");
    property p_hit; label_hits_trace |=> sp_w; endproperty
    a_hit: assert property (p_hit) else $error("label on trace");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_busy; tx_valid |-> !rx_ready; endproperty
    a_busy: assert property (p_busy) else $error("input open");
    c_err: cover property ($rose(syntax_err));
    c_stall: cover property (tx_valid && !tx_ready);
    c_row0: cover property (label_row == 4'h0);
endmodule
bind acti_core acti_core_asserts u_chk (.*);

// File: acti_host.sv
// Bus controller model: sends command bytes, takes answer bytes
`timescale 1ns/1ns
module acti_host (
    // Clock
    input wire logic clk,
    // Command bytes out
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Answer bytes in
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];
    bit slow = 1'h0;
    initial rx_valid = 1'h0;
    initial rx_data = 8'h00;
    initial tx_ready = 1'h0;
    // Slow sink stalls every other cycle to test holding
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= !slow || !tx_ready;
    end
    // Raw bytes held until taken, no line end added; idle shows inverse
    task automatic send(input logic [7:0] q[$]);
        @(posedge clk);
        foreach (q[i]) begin
            rx_data <= q[i];
            rx_valid <= 1'h1;
            do @(posedge clk); while (!rx_ready);
        end
        rx_valid <= 1'h0;
        rx_data <= ~rx_data;
    endtask
endmodule

// File: tb_top.sv
// Bench for the label and trace interpreter
`timescale 1ns/1ns
module tb_top import acti_pkg::*;;
    logic clk = 1'h0;
    logic rstn, dev_clear, status_clear, panel_clear_key, label_hits_trace;
    logic rx_valid, rx_ready, tx_valid, tx_ready, syntax_err;
    logic [7:0] rx_data, tx_data, q[$], e[$], e2[$];
    logic [8:0] disp_x;
    logic [5:0] disp_col;
    logic [3:0] label_row;
    acti_disp_s disp;
    int n_fail = 0, n_tests = 0, v;
    string s;
    acti_core #(.HOLD_CYC(8)) DUT (.*);
    acti_host host (.*);
    // Case inequality so an unknown never passes
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("fails %0d of %0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic void app(ref logic [7:0] d[$], input string x);
        for (int k = 0; k < x.len(); k++) d.push_back(x[k]);
    endfunction
    // Sends text, waits boundedly for n bytes, compares against e
    task automatic ask(input string c, input int n);
        q = {};
        app(q, c);
        host.got = {};
        host.send(q);
        for (int i = 0; i < 20000 && host.got.size() < n; i++) @(posedge clk);
        repeat (9) @(posedge clk);
        chk(host.got.size(), n);
        foreach (e[i]) chk(host.got[i], e[i]);
    endtask
    // Unknown codes, resync, and the three clear paths
    task automatic t_err;
        e = {};
        ask("QQLP3", 0);
        chk(syntax_err, 1);
        chk(label_row, 3);
        dev_clear <= 1'h1;
        @(posedge clk) dev_clear <= 1'h0;
        @(posedge clk) chk(syntax_err, 0);
        ask("9Q1LP0", 0);
        chk(label_row, 0);
        status_clear <= 1'h1;
        @(posedge clk) status_clear <= 1'h0;
        @(posedge clk) chk(syntax_err, 0);
        ask("YZLP8", 0);
        chk(syntax_err, 1);
        panel_clear_key <= 1'h1;
        repeat (20) @(posedge clk);
        panel_clear_key <= 1'h0;
        chk(syntax_err, 0);
    endtask
    // Over-long text, terminators, restore, dump, label pixels
    task automatic t_label;
        e = {};
        ask({"LUAB", {58{" "}}, "ZZ\015LLxy\003RL"}, 0);
        disp_col <= 6'h01;
        label_hits_trace <= 1'h1;
        @(posedge clk) label_hits_trace <= 1'h0;
        @(posedge clk) chk(disp.upper_ch, CH_SPACE);
        @(posedge clk) chk(disp.upper_ch, CH_B);
        chk(disp.lower_ch, CH_SPACE);
        app(e, {"AB", {58{" "}}, "\003", {60{" "}}, "\003"});
        ask("CS", 122);
        // Restore then dump in one message: both lines back to blank
        e = {};
        app(e, {{60{" "}}, "\003", {60{" "}}, "\003"});
        ask("RUCS", 122);
    endtask
    // Binary load of trace 1 (hi byte first), read-outs, peak tie
    task automatic t_trace;
        q = {8'h4A, 8'h41};
        e = {};
        for (int i = 0; i < TRACE_PTS; i++) begin
            v = i % 240 - 50;
            q.push_back(8'(v >>> 8));
            q.push_back(8'(v));
            v = v < -48 ? -50 : v;
            e.push_back(8'(v >>> 8));
            e.push_back(8'(v));
            s = v < 0 ? $sformatf("-%02d", -v) : $sformatf("%03d", v);
            app(e2, i ? {",", s} : s);
        end
        host.send(q);
        ask("BA", 962);
        host.slow = 1'h1;
        e = e2;
        ask("TA", 1923);
        host.slow = 1'h0;
        e = {};
        app(e, "239,189");
        ask("AP", 7);
        disp_x <= 9'h002;
        @(posedge clk) disp_x <= 9'h001;
        @(posedge clk) chk(disp.level1, -48);
        @(posedge clk) chk(disp.blank1, 1);
        e = {8'h01, 8'h2C, 8'hFF, 8'hCE, 8'h00, 8'h07};
        ask("IB300,-50,7;BB", 962);
        // Trace 2 pixels: first point drawn, second blanked
        disp_x <= 9'h000;
        @(posedge clk) disp_x <= 9'h001;
        @(posedge clk) chk(disp.level2, 300);
        @(posedge clk) chk(disp.blank2, 1);
    endtask
    initial forever #10 clk = ~clk;
    initial begin
        {rstn, dev_clear, status_clear, panel_clear_key} = 4'h0;
        {label_hits_trace, disp_x, disp_col} = 16'h0000;
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_err;
        t_label;
        t_trace;
        summarize;
    end
    // Run needs about 12k cycles; a hang is cut at 100k
    initial begin
        #2000000;
        n_fail++;
        summarize;
    end
endmodule
